/* File: hraf_pkg.sv */
// constants, types and register map of the receive address filter
//
// Functional notes
// - the two-bit protocol field picks HDLC, transparent one, transparent two or reserved per channel.
// - transparent one honours the fill character, transparent two ignores it.
// - the flag status bit is set by a received flag or frame and cleared only by software.
// - received CRC bytes are passed on to memory only when CRC storage is enabled.
// - first-byte value recognition drops a frame whose first byte misses the stored low byte.
// - first-byte broadcast recognition drops a frame whose first byte is not all ones.
// - second-byte value recognition drops a frame whose second byte misses the stored high byte.
// - second-byte broadcast recognition drops a frame whose second byte is not all ones.
// - with both checks on one position either may pass, and both positions must pass.
// - with all four recognition enables clear every frame is accepted.
// - writing the access register launches the indirect read or write of recognition memory.
// - the mask-select bit steers the indirect access to mask memory or to value memory.
// - the five-bit channel field picks which of the 32 channels the access reaches.
// - the data register holds first byte low and second byte high, values or masks alike.
// - only address bits whose mask bit is 0 are compared, any compared mismatch drops.
// - in transparent one a single fill character ends the current message.
package hraf_pkg;

	// register indices; the byte address is four times the index
	localparam logic [5:0] HRAF_IDX_RX_CMD = 6'h1a;
	localparam logic [5:0] HRAF_IDX_ACCESS = 6'h1c;
	localparam logic [5:0] HRAF_IDX_DATA = 6'h1e;
	localparam logic [5:0] HRAF_IDX_FILL = 6'h20;

	localparam logic [15:0] HRAF_RESET16 = 16'h0000;

	// receive command register fields
	localparam int HRAF_CMD_LSB = 0;
	localparam int HRAF_CMD_MSB = 9;
	localparam int HRAF_P_LSB = 2;
	localparam int HRAF_FS_BIT = 4;
	localparam int HRAF_CRC_BIT = 5;
	localparam int HRAF_EN1V_BIT = 6;
	localparam int HRAF_EN1F_BIT = 7;
	localparam int HRAF_EN2V_BIT = 8;
	localparam int HRAF_EN2F_BIT = 9;
	// read bit and channel field are shared by the command and access registers; mask select and masks are not
	localparam int HRAF_READ_BIT = 10;
	localparam int HRAF_CH_LSB = 11;
	localparam int HRAF_MSEL_BIT = 9;
	localparam logic [15:0] HRAF_ACCESS_MASK = 16'hfe00;
	localparam logic [15:0] HRAF_FILL_MASK = 16'h00ff;

	localparam logic [1:0] HRAF_RESP_OKAY = 2'h0;
	localparam logic [1:0] HRAF_RESP_SLVERR = 2'h2;
	localparam logic [7:0] HRAF_ONES = 8'hff;

	// bytes seen since the opening flag
	localparam logic [1:0] HRAF_CNT_NONE = 2'h0;
	localparam logic [1:0] HRAF_CNT_ONE = 2'h1;
	localparam logic [1:0] HRAF_CNT_MORE = 2'h2;

	typedef enum logic [1:0] {
		HRAF_MODE_HDLC = 2'h0,
		HRAF_MODE_TR1 = 2'h1,
		HRAF_MODE_TR2 = 2'h2,
		HRAF_MODE_RSVD = 2'h3
	} hraf_mode_t;

	typedef enum logic [2:0] {
		HRAF_K_OPEN = 3'h0,
		HRAF_K_DATA = 3'h1,
		HRAF_K_CRC = 3'h2,
		HRAF_K_CLOSE = 3'h3,
		HRAF_K_ABORT = 3'h4
	} hraf_kind_t;

	typedef enum logic [1:0] {
		HRAF_BS_IDLE = 2'b00,
		HRAF_BS_RESP = 2'b01
	} hraf_bus_state_t;

	typedef struct packed {
		logic valid;
		hraf_kind_t kind;
		logic [4:0] chan;
		logic [7:0] data;
	} hraf_rx_in_t;

	typedef struct packed {
		logic valid;
		logic pair;
		logic [4:0] chan;
		logic [15:0] data;
	} hraf_rx_out_t;

	typedef struct packed {
		logic valid;
		logic [4:0] chan;
	} hraf_done_t;

endpackage : hraf_pkg

/* File: hraf_rx_filter.sv */
// receive address filter with per-channel mode, flag status and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module hraf_rx_filter #(
	parameter int ADDR_W = 8,
	parameter int CHAN_W = 5
) (
	input wire logic clk, // 250 MHz clock
	input wire logic rst_b, // synchronous reset, low active
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire hraf_pkg::hraf_rx_in_t rx_in, // deframed event from the receiver
	output hraf_pkg::hraf_rx_out_t rx_out, // bytes bound for external memory
	output hraf_pkg::hraf_done_t frame_done, // frame or message completed
	output logic [31:0] flag_seen_status // per-channel flag status
);
	import hraf_pkg::*;

	localparam int NCH = 1 << CHAN_W;

	if (CHAN_W != 5) begin : g_chk_chan
		$error("channel field is five bits wide");
	end
	if (ADDR_W < 8) begin : g_chk_addr
		$error("address too narrow for the register map");
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		wmerge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : wmerge

	// one address position: value match under mask, or all ones, or no check
	function automatic logic pos_ok(input logic [7:0] rx, input logic [7:0] exp,
		input logic [7:0] msk, input logic val_en, input logic ones_en);
		logic val_hit;
		logic ones_hit;
		val_hit = ((rx ^ exp) & ~msk) == 8'h00;
		ones_hit = rx == HRAF_ONES;
		pos_ok = (!val_en && !ones_en) || (val_en && val_hit) || (ones_en && ones_hit);
	endfunction : pos_ok

	////////////////////////////////////////////////////////////////////////////
	// register and memory state

	hraf_bus_state_t wst, next_wst;
	hraf_bus_state_t rst_q, next_rst_q;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [ADDR_W-1:0] waddr, next_waddr;
	logic [31:0] wdata, next_wdata;
	logic [3:0] wstrb, next_wstrb;
	logic awready, next_awready;
	logic wready, next_wready;
	logic arready, next_arready;
	logic [1:0] bresp, next_bresp;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic [15:0] rx_cmd, next_rx_cmd;
	logic [15:0] access, next_access;
	logic [15:0] rdata16, next_rdata16;
	logic [15:0] fill, next_fill;
	logic [9:0] cmd_mem [NCH], next_cmd_mem [NCH];
	logic [15:0] val_mem [NCH], next_val_mem [NCH];
	logic [15:0] mask_mem [NCH], next_mask_mem [NCH];
	logic [31:0] fseen, next_fseen;
	logic [31:0] fseen_set;

	always_comb begin
		logic [5:0] widx;
		logic [5:0] ridx;
		logic [15:0] wv;
		logic [CHAN_W-1:0] ch;
		widx = waddr[ADDR_W-1:2] == ADDR_W'(0) ? 6'h00 : waddr[7:2];
		ridx = s_axi_araddr[7:2];
		wv = 16'h0000;
		ch = '0;
		next_wst = wst;
		next_rst_q = rst_q;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bresp = bresp;
		next_rdata = rdata;
		next_rresp = rresp;
		next_rx_cmd = rx_cmd;
		next_access = access;
		next_rdata16 = rdata16;
		next_fill = fill;
		next_cmd_mem = cmd_mem;
		next_val_mem = val_mem;
		next_mask_mem = mask_mem;
		next_fseen = fseen | fseen_set;
		if (ADDR_W > 8 && waddr[ADDR_W-1:2] != ADDR_W'(widx)) begin
			widx = 6'h3f;
		end

		// write channel: address and data taken in either order
		if (s_axi_awvalid && awready) begin
			next_aw_held = 1'b1;
			next_waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready) begin
			next_w_held = 1'b1;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		unique case (wst)
			HRAF_BS_IDLE: begin
				if (aw_held && w_held) begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_wst = HRAF_BS_RESP;
					next_bresp = HRAF_RESP_OKAY;
					unique case (widx)
						HRAF_IDX_RX_CMD: begin
							wv = wmerge(rx_cmd, wdata, wstrb);
							ch = wv[HRAF_CH_LSB +: CHAN_W];
							if (wv[HRAF_READ_BIT]) begin
								next_rx_cmd = {wv[15:HRAF_READ_BIT], cmd_mem[ch][9:5],
									fseen[ch], cmd_mem[ch][3:0]};
							end else begin
								next_rx_cmd = wv;
								next_cmd_mem[ch] = wv[HRAF_CMD_MSB:HRAF_CMD_LSB];
								// software only clears; a flag in the same cycle wins
								if (!wv[HRAF_FS_BIT]) begin
									next_fseen[ch] = fseen_set[ch];
								end
							end
						end
						HRAF_IDX_ACCESS: begin
							wv = wmerge(access, wdata, wstrb) & HRAF_ACCESS_MASK;
							ch = wv[HRAF_CH_LSB +: CHAN_W];
							next_access = wv;
							if (wv[HRAF_READ_BIT]) begin
								next_rdata16 = wv[HRAF_MSEL_BIT] ? mask_mem[ch] : val_mem[ch];
							end else if (wv[HRAF_MSEL_BIT]) begin
								next_mask_mem[ch] = rdata16;
							end else begin
								next_val_mem[ch] = rdata16;
							end
						end
						HRAF_IDX_DATA: next_rdata16 = wmerge(rdata16, wdata, wstrb);
						HRAF_IDX_FILL: next_fill = wmerge(fill, wdata, wstrb) & HRAF_FILL_MASK;
						default: next_bresp = HRAF_RESP_SLVERR;
					endcase
				end
			end
			HRAF_BS_RESP: begin
				if (s_axi_bready) begin
					next_wst = HRAF_BS_IDLE;
				end
			end
			default: next_wst = HRAF_BS_IDLE;
		endcase
		next_awready = !next_aw_held && next_wst == HRAF_BS_IDLE;
		next_wready = !next_w_held && next_wst == HRAF_BS_IDLE;

		// read channel; flag status reads through the command register as captured by the last read command
		unique case (rst_q)
			HRAF_BS_IDLE: begin
				if (s_axi_arvalid && arready) begin
					next_rst_q = HRAF_BS_RESP;
					next_rresp = HRAF_RESP_OKAY;
					next_rdata = 32'h0000_0000;
					if (ADDR_W > 8 && s_axi_araddr[ADDR_W-1:2] != ADDR_W'(ridx)) begin
						next_rresp = HRAF_RESP_SLVERR;
					end else begin
						unique case (ridx)
							HRAF_IDX_RX_CMD: next_rdata[15:0] = rx_cmd;
							HRAF_IDX_ACCESS: next_rdata[15:0] = access;
							HRAF_IDX_DATA: next_rdata[15:0] = rdata16;
							HRAF_IDX_FILL: next_rdata[15:0] = fill;
							default: next_rresp = HRAF_RESP_SLVERR;
						endcase
					end
				end
			end
			HRAF_BS_RESP: begin
				if (s_axi_rready) begin
					next_rst_q = HRAF_BS_IDLE;
				end
			end
			default: next_rst_q = HRAF_BS_IDLE;
		endcase
		next_arready = next_rst_q == HRAF_BS_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wst <= HRAF_BS_IDLE;
			rst_q <= HRAF_BS_IDLE;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			waddr <= '0;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bresp <= HRAF_RESP_OKAY;
			rdata <= 32'h0000_0000;
			rresp <= HRAF_RESP_OKAY;
			rx_cmd <= HRAF_RESET16;
			access <= HRAF_RESET16;
			rdata16 <= HRAF_RESET16;
			fill <= HRAF_RESET16;
			fseen <= 32'h0000_0000;
			for (int i = 0; i < NCH; i++) begin
				cmd_mem[i] <= 10'h000;
				val_mem[i] <= HRAF_RESET16;
				mask_mem[i] <= HRAF_RESET16;
			end
		end else begin
			wst <= next_wst;
			rst_q <= next_rst_q;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			awready <= next_awready;
			wready <= next_wready;
			arready <= next_arready;
			bresp <= next_bresp;
			rdata <= next_rdata;
			rresp <= next_rresp;
			rx_cmd <= next_rx_cmd;
			access <= next_access;
			rdata16 <= next_rdata16;
			fill <= next_fill;
			fseen <= next_fseen;
			cmd_mem <= next_cmd_mem;
			val_mem <= next_val_mem;
			mask_mem <= next_mask_mem;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel frame tracking and address filtering

	logic active [NCH], next_active [NCH];
	logic discard [NCH], next_discard [NCH];
	logic [1:0] cnt [NCH], next_cnt [NCH];
	logic [7:0] held [NCH], next_held [NCH];
	hraf_rx_out_t out_q, next_out_q;
	hraf_done_t done_q, next_done_q;

	always_comb begin
		logic [CHAN_W-1:0] c;
		logic [9:0] cmd;
		hraf_mode_t mode;
		logic ok1;
		logic ok2;
		logic sec_en;
		c = rx_in.chan;
		cmd = cmd_mem[c];
		mode = hraf_mode_t'(cmd[HRAF_P_LSB +: 2]);
		sec_en = cmd[HRAF_EN2V_BIT] || cmd[HRAF_EN2F_BIT];
		ok1 = pos_ok(rx_in.data, val_mem[c][7:0], mask_mem[c][7:0],
			cmd[HRAF_EN1V_BIT], cmd[HRAF_EN1F_BIT]);
		ok2 = pos_ok(rx_in.data, val_mem[c][15:8], mask_mem[c][15:8],
			cmd[HRAF_EN2V_BIT], cmd[HRAF_EN2F_BIT]);
		next_active = active;
		next_discard = discard;
		next_cnt = cnt;
		next_held = held;
		next_out_q = '0;
		next_done_q = '0;
		next_out_q.chan = c;
		next_done_q.chan = c;
		fseen_set = 32'h0000_0000;
		if (rx_in.valid) begin
			unique case (mode)
				HRAF_MODE_HDLC: begin
					unique case (rx_in.kind)
						HRAF_K_OPEN: begin
							fseen_set[c] = 1'b1;
							next_active[c] = 1'b1;
							next_discard[c] = 1'b0;
							next_cnt[c] = HRAF_CNT_NONE;
						end
						HRAF_K_DATA: begin
							fseen_set[c] = 1'b1;
							if (active[c] && !discard[c]) begin
								// first byte is held so a late mismatch leaves nothing in memory
								if (cnt[c] == HRAF_CNT_NONE) begin
									next_held[c] = rx_in.data;
									next_cnt[c] = HRAF_CNT_ONE;
									next_discard[c] = !ok1;
								end else if (cnt[c] == HRAF_CNT_ONE) begin
									next_cnt[c] = HRAF_CNT_MORE;
									next_discard[c] = !ok2;
									next_out_q.valid = ok2;
									next_out_q.pair = 1'b1;
									next_out_q.data = {rx_in.data, held[c]};
								end else begin
									next_out_q.valid = 1'b1;
									next_out_q.data = {8'h00, rx_in.data};
								end
							end
						end
						HRAF_K_CRC: begin
							if (active[c] && !discard[c] && cnt[c] == HRAF_CNT_MORE) begin
								next_out_q.valid = cmd[HRAF_CRC_BIT];
								next_out_q.data = {8'h00, rx_in.data};
							end
						end
						HRAF_K_CLOSE: begin
							fseen_set[c] = 1'b1;
							if (active[c] && !discard[c] && cnt[c] != HRAF_CNT_NONE) begin
								// a one-byte frame cannot pass a second-byte check
								if (cnt[c] == HRAF_CNT_MORE || !sec_en) begin
									next_done_q.valid = 1'b1;
									next_out_q.valid = cnt[c] == HRAF_CNT_ONE;
									next_out_q.data = {8'h00, held[c]};
								end
							end
							next_active[c] = 1'b0;
						end
						HRAF_K_ABORT: next_active[c] = 1'b0;
						default: next_active[c] = 1'b0;
					endcase
				end
				HRAF_MODE_TR1: begin
					if (rx_in.kind == HRAF_K_DATA) begin
						if (rx_in.data == fill[7:0]) begin
							next_done_q.valid = active[c];
							next_active[c] = 1'b0;
						end else begin
							next_active[c] = 1'b1;
							next_out_q.valid = 1'b1;
							next_out_q.data = {8'h00, rx_in.data};
						end
					end
				end
				HRAF_MODE_TR2: begin
					if (rx_in.kind == HRAF_K_DATA) begin
						next_out_q.valid = 1'b1;
						next_out_q.data = {8'h00, rx_in.data};
					end
				end
				HRAF_MODE_RSVD: next_active[c] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out_q <= '0;
			done_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				active[i] <= 1'b0;
				discard[i] <= 1'b0;
				cnt[i] <= HRAF_CNT_NONE;
				held[i] <= 8'h00;
			end
		end else begin
			out_q <= next_out_q;
			done_q <= next_done_q;
			active <= next_active;
			discard <= next_discard;
			cnt <= next_cnt;
			held <= next_held;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign s_axi_awready = awready;
	assign s_axi_wready = wready;
	assign s_axi_bvalid = wst[0];
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid = rst_q[0];
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign rx_out = out_q;
	assign frame_done = done_q;
	assign flag_seen_status = fseen;

endmodule : hraf_rx_filter
`default_nettype wire

/* File: hraf_rx_filter_bench.sv */
// self-checking bench for the receive address filter
`timescale 1ns/10ps
`default_nettype none
module hraf_rx_filter_bench;
	import hraf_pkg::*;
	localparam logic [7:0] a_cmd = {HRAF_IDX_RX_CMD, 2'b00};
	localparam logic [7:0] a_acc = {HRAF_IDX_ACCESS, 2'b00};
	localparam logic [7:0] a_dat = {HRAF_IDX_DATA, 2'b00};
	localparam logic [7:0] a_fill = {HRAF_IDX_FILL, 2'b00};
	// {enables 21/20/11/10, first byte, second byte, accepted}
	localparam logic [20:0] tbl [13] = '{{4'h0, 8'h3d, 8'h77, 1'b1},
		{4'h1, 8'h3c, 8'h00, 1'b1}, {4'h1, 8'h3d, 8'h00, 1'b0}, {4'h2, 8'hff, 8'h00, 1'b1},
		{4'h2, 8'h3c, 8'h00, 1'b0}, {4'h4, 8'h00, 8'h5a, 1'b1}, {4'h4, 8'h00, 8'h5b, 1'b0},
		{4'h8, 8'h00, 8'hff, 1'b1}, {4'h8, 8'h00, 8'h5a, 1'b0}, {4'h3, 8'hff, 8'h12, 1'b1},
		{4'h3, 8'h3c, 8'h12, 1'b1}, {4'hf, 8'h3c, 8'h11, 1'b0}, {4'hf, 8'hff, 8'h5a, 1'b1}};
	logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, flag_seen_status, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] last_pair;
	hraf_rx_in_t rx_in;
	hraf_rx_out_t rx_out;
	hraf_done_t frame_done;
	int errors = 0, comparisons = 0, cnt_out = 0, cnt_done = 0;
	hraf_rx_filter uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_in(rx_in),
		.rx_out(rx_out), .frame_done(frame_done), .flag_seen_status(flag_seen_status));
	hraf_rx_src src (.clk(clk), .rx_in(rx_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_out.valid === 1'b1) begin
			cnt_out <= cnt_out + 1;
			if (rx_out.pair === 1'b1) last_pair <= rx_out.data;
		end
		if (frame_done.valid === 1'b1) cnt_done <= cnt_done + 1;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic axi_write(input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 40) errors++;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 40) errors++;
	endtask : axi_read
	task automatic cfg(input logic [4:0] ch, input logic [3:0] ar, input logic crc,
		input logic [1:0] p);
		axi_write(a_cmd, {ch, 1'b0, ar, crc, 1'b0, p, 2'b00}); // status bit written 0 clears it
	endtask : cfg
	task automatic recog(input logic [4:0] ch, input logic rd_sel, input logic msk,
		input logic [15:0] v);
		if (!rd_sel) axi_write(a_dat, v);
		axi_write(a_acc, {ch, rd_sel, msk, 9'h000});
	endtask : recog
	////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		check("status at reset", flag_seen_status, 32'h0);
		axi_read(a_acc);
		check("access reset", rd, 32'h0);
		axi_read(a_dat);
		check("data reset", rd, 32'h0);
		axi_read(a_fill);
		check("fill reset", rd, 32'h0);
		axi_read(8'hfc);
		check("unmapped read", {30'h0, rs}, {30'h0, HRAF_RESP_SLVERR});
		axi_write(8'hfc, 16'h1234);
		check("unmapped write", {30'h0, rs}, {30'h0, HRAF_RESP_SLVERR});
	endtask : t_reset_values
	task automatic t_recog_memory;
		recog(5'd2, 1'b0, 1'b0, 16'h5a3c);
		recog(5'd5, 1'b0, 1'b0, 16'h1234);
		recog(5'd5, 1'b0, 1'b1, 16'h00f0);
		recog(5'd2, 1'b1, 1'b0, 16'h0000);
		axi_read(a_dat);
		check("value ch2", rd, 32'h5a3c);
		recog(5'd5, 1'b1, 1'b1, 16'h0000);
		axi_read(a_dat);
		check("mask ch5", rd, 32'h00f0);
		axi_read(a_acc);
		check("access readback", rd, 32'h2e00);
		recog(5'd5, 1'b1, 1'b0, 16'h0000);
		axi_read(a_dat);
		check("value ch5", rd, 32'h1234);
	endtask : t_recog_memory
	task automatic t_address_table;
		int o, d;
		for (int i = 0; i < 13; i++) begin
			cfg(5'd2, tbl[i][20:17], 1'b1, HRAF_MODE_HDLC);
			o = cnt_out;
			d = cnt_done;
			src.frame(5'd2, tbl[i][16:9], tbl[i][8:1]);
			check("accepted bytes", 32'(cnt_out - o), tbl[i][0] ? 32'd4 : 32'd0);
			check("accepted done", 32'(cnt_done - d), {31'h0, tbl[i][0]});
			if (tbl[i][0]) begin
				check("pair", 32'(last_pair), {16'h0, tbl[i][8:1], tbl[i][16:9]});
			end
		end
	endtask : t_address_table
	task automatic t_mask;
		int o;
		recog(5'd2, 1'b0, 1'b1, 16'h000f);
		cfg(5'd2, 4'h1, 1'b1, HRAF_MODE_HDLC);
		o = cnt_out;
		src.frame(5'd2, 8'h35, 8'h00);
		check("masked bits ignored", 32'(cnt_out - o), 32'd4);
		src.frame(5'd2, 8'h25, 8'h00);
		check("unmasked bit drops", 32'(cnt_out - o), 32'd4);
		recog(5'd2, 1'b0, 1'b1, 16'h0000);
	endtask : t_mask
	task automatic t_crc_flag;
		int o, d;
		cfg(5'd2, 4'h0, 1'b0, HRAF_MODE_HDLC);
		check("status cleared", {31'h0, flag_seen_status[2]}, 32'h0);
		o = cnt_out;
		src.frame(5'd2, 8'h3d, 8'h77);
		check("no crc bytes", 32'(cnt_out - o), 32'd2);
		repeat (20) @(posedge clk);
		check("status held", {31'h0, flag_seen_status[2]}, 32'h1);
		// read command: stored channel 2 settings with status as captured by the read command come back
		axi_write(a_cmd, 16'h1400);
		axi_read(a_cmd);
		check("command readback", rd, 32'h1410);
		o = cnt_out;
		d = cnt_done;
		src.send(HRAF_K_OPEN, 5'd2, 8'h7e);
		src.send(HRAF_K_DATA, 5'd2, 8'h3d);
		src.send(HRAF_K_ABORT, 5'd2, 8'hff);
		src.send(HRAF_K_CLOSE, 5'd2, 8'h7e);
		repeat (2) @(posedge clk);
		check("aborted frame", 32'(cnt_out - o + cnt_done - d), 32'd0);
	endtask : t_crc_flag
	task automatic t_transparent;
		int o, d;
		axi_write(a_fill, 16'h00a5);
		axi_read(a_fill);
		check("fill readback", rd, 32'h00a5);
		for (int p = 1; p < 4; p++) begin
			cfg(5'd3, 4'h0, 1'b0, 2'(p));
			o = cnt_out;
			d = cnt_done;
			src.send(HRAF_K_DATA, 5'd3, 8'h11);
			src.send(HRAF_K_DATA, 5'd3, 8'ha5);
			repeat (2) @(posedge clk);
			check("mode bytes", 32'(cnt_out - o), p == 1 ? 32'd1 : p == 2 ? 32'd2 : 32'd0);
			check("mode done", 32'(cnt_done - d), p == 1 ? 32'd1 : 32'd0);
		end
	endtask : t_transparent
	initial begin
		#40000;
		errors++;
		end_of_test();
	end
	initial begin
		rst_b = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'h3;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_values();
		t_recog_memory();
		t_address_table();
		t_mask();
		t_crc_flag();
		t_transparent();
		end_of_test();
	end
endmodule : hraf_rx_filter_bench
`default_nettype wire

/* File: hraf_rx_filter_sva.sv */
// port assertions for the receive address filter
`timescale 1ns/10ps
`default_nettype none
module hraf_rx_filter_sva #(
	parameter int ADDR_W = 8,
	parameter int CHAN_W = 5
) (
	input wire logic clk, // clock
	input wire logic rst_b, // synchronous reset, low active
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	input wire hraf_pkg::hraf_rx_in_t rx_in, // receiver events
	input wire hraf_pkg::hraf_rx_out_t rx_out, // bytes to memory
	input wire hraf_pkg::hraf_done_t frame_done, // completion pulse
	input wire logic [31:0] flag_seen_status // flag status
);
	import hraf_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_ev(hraf_kind_t k);
		rx_in.valid && rx_in.kind == k;
	endsequence
	sequence s_silent;
		!rx_out.valid && !frame_done.valid;
	endsequence
	chk_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
		else $error("read not answered");
	// status may only drop on the edge that completes a register write
	chk_flag_sw_only: assert property (|($past(flag_seen_status) & ~flag_seen_status)
		|-> $rose(s_axi_bvalid))
		else $error("flag status cleared without a write");
	chk_open_emits_none: assert property (s_ev(HRAF_K_OPEN) |=> s_silent)
		else $error("opening flag produced output");
	chk_abort_emits_none: assert property (s_ev(HRAF_K_ABORT) |=> s_silent)
		else $error("aborted frame produced output");
	chk_out_has_cause: assert property (rx_out.valid |->
		$past(rx_in.valid) && $past(rx_in.chan) == rx_out.chan)
		else $error("output without matching event");
	chk_pair_order: assert property (rx_out.valid && rx_out.pair |->
		$past(rx_in.kind) == HRAF_K_DATA && rx_out.data[15:8] == $past(rx_in.data))
		else $error("address pair out of order");
	chk_done_cause: assert property (frame_done.valid |-> $past(rx_in.valid) &&
		$past(rx_in.kind) inside {HRAF_K_CLOSE, HRAF_K_DATA})
		else $error("completion without closing event");
endmodule : hraf_rx_filter_sva
bind hraf_rx_filter hraf_rx_filter_sva #(.ADDR_W(ADDR_W), .CHAN_W(CHAN_W)) u_sva (
	.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .rx_in(rx_in), .rx_out(rx_out),
	.frame_done(frame_done), .flag_seen_status(flag_seen_status));
`default_nettype wire

/* File: hraf_rx_src.sv */
// model of the deframing receiver that feeds the filter
`timescale 1ns/10ps
`default_nettype none
module hraf_rx_src (
	input wire logic clk, // clock
	output var hraf_pkg::hraf_rx_in_t rx_in // event toward the filter
);
	import hraf_pkg::*;
	initial rx_in = '0;
	// idle payload is inverted so a stale byte never passes for a fresh one
	task automatic send(input hraf_kind_t kind, input logic [4:0] chan, input logic [7:0] data);
		@(posedge clk);
		rx_in <= '{valid: 1'b1, kind: kind, chan: chan, data: data};
		@(posedge clk);
		rx_in <= '{valid: 1'b0, kind: kind, chan: chan, data: ~data};
	endtask : send
	task automatic frame(input logic [4:0] chan, input logic [7:0] a, input logic [7:0] b);
		send(HRAF_K_OPEN, chan, 8'h7e);
		send(HRAF_K_DATA, chan, a);
		send(HRAF_K_DATA, chan, b);
		send(HRAF_K_DATA, chan, 8'h44);
		send(HRAF_K_CRC, chan, 8'h91);
		send(HRAF_K_CRC, chan, 8'h92);
		send(HRAF_K_CLOSE, chan, 8'h7e);
		repeat (3) @(posedge clk);
	endtask : frame
endmodule : hraf_rx_src
`default_nettype wire
